/* File: hdl/pmm_top.sv */
/*
  Packet memory manager: command register, packet select, allocation result,
  queue ports and auto-release of transmitted packets.
  Assumes a synchronous 16-bit register port and a transmit engine outside.
*/
// Function
// - auto release frees successful packets except while busy, only unsuccessful ones enter done queue
// - chained sends raise only drained event or fault event
// - fatal error clears transmit enable, keeps failed packet queued and allocated
// - code 0000 changes nothing
// - command 0010 allocates (count+1) pages of 256 bytes, count 0..5
// - allocation updates result register at once, pulses done on success
// - allocation ends within (count+2) times 200 us
// - command 0100 frees all, sets failed flag, resets queue pointers
// - command 0110 pops receive queue head without freeing
// - command 0111 pops transmit queue head
// - command 1000 pops receive head and frees its pages
// - command 1010 frees packet named in packet select
// - command 1100 enqueues packet select number to transmit queue
// - command 1110 empties transmit and done queues, frees nothing
// - busy at bit 0 of command address, busy and failed set at write end
// - packet select steers transmit area and clears on hardware reset and command 0100, not on 1110
// - failed flag clear on success, sticky on failure, set after resets
// - result register holds last allocated packet number
// - receive head number shown with empty flag
`timescale 1ns/1ps
module pmm_top
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        rx_push,
  input  wire logic [4:0]  rx_push_num,
  input  wire logic        tx_done,
  input  wire logic        tx_success_flag,
  input  wire logic        tx_fatal,
  output logic      [4:0]  tx_head,
  output logic             tx_queue_empty,
  output logic             tx_pop_done,
  output logic      [4:0]  tx_area_packet,
  output logic             transmit_enable_bit,
  output logic             alloc_done_irq,
  output logic             tx_queue_drained_irq,
  output logic             tx_fault_irq,
  output logic      [4:0]  rx_head,
  output logic             rx_queue_empty,
  output logic             done_queue_empty
);
  import pmm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic                 rst_meta;
  logic                 rst_n;
  logic [15:0]          controller_control;
  logic [7:0]           tx_packet_select;
  logic [7:0]           allocation_result;
  logic [NPAGE-1:0]     page_used;
  logic [2:0]           page_cnt [NPKT];
  logic [4:0]           page_base [NPKT];
  logic [NPKT-1:0]      pkt_used;
  logic                 alloc_pend;
  logic [2:0]           alloc_cnt;
  logic [15:0]          alloc_timer;
  pmm_rel_state_t       rel_state;
  logic [4:0]           rel_num;
  logic [2:0]           rel_timer;
  logic                 cmd_wr;
  pmm_cmd_t             cmd;
  logic                 do_free;
  logic [4:0]           free_num;
  logic                 mmu_reset;
  logic                 tx_flush;
  logic                 rx_pop;
  logic                 tx_pop;
  logic                 done_push;
  logic                 fit_ok;
  logic [4:0]           fit_page;
  logic [4:0]           fit_pkt;
  logic [4:0]           done_head;
  logic                 busy;
  logic                 alloc_grant;
  logic                 tx_popped;

  function automatic logic [NPAGE-1:0] run_mask(input logic [4:0] base,
                                               input logic [2:0] cnt);
    logic [NPAGE-1:0] m;
    m = '0;
    for (int i = 0; i < MAX_PAGES; i++)
      if (i <= int'(cnt) && (int'(base) + i) < NPAGE)
        m[int'(base) + i] = 1'b1;
    return m;
  endfunction : run_mask

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cmd_wr    = reg_wr && (reg_addr == OFS_CMD);
  assign cmd       = pmm_cmd_t'(reg_wdata[7:4]);
  assign mmu_reset = cmd_wr && (cmd == PMM_RESET);
  assign tx_flush  = mmu_reset || (cmd_wr && (cmd == PMM_TX_RESET));
  assign rx_pop    = cmd_wr && ((cmd == PMM_RX_POP) || (cmd == PMM_RX_REL));
  assign tx_pop    = (cmd_wr && (cmd == PMM_TX_POP)) || tx_pop_done;
  // successful sends skip the done queue under auto release
  assign done_push = tx_done && !(controller_control[CTL_AUTO_REL] && tx_success_flag);
  assign tx_pop_done = tx_done && !tx_fatal;
  assign busy        = (rel_state == PMM_REL);
  assign tx_area_packet = tx_packet_select[4:0];
  assign transmit_enable_bit = controller_control[CTL_TRANSMIT_ENABLE_BIT];
  // a starved request looks again once per step, never mid-step
  assign alloc_grant = alloc_pend && fit_ok && !cmd_wr && (alloc_timer == 16'h0000);

  // first free run of pages large enough, plus first free packet number
  always_comb
  begin
    fit_ok   = 1'b0;
    fit_page = 5'h00;
    fit_pkt  = 5'h00;
    for (int p = NPAGE - 1; p >= 0; p--)
      if (p + int'(alloc_cnt) < NPAGE &&
          (page_used & run_mask(5'(p), alloc_cnt)) == '0)
      begin
        fit_ok   = 1'b1;
        fit_page = 5'(p);
      end
    for (int k = NPKT - 1; k >= 0; k--)
      if (!pkt_used[k])
        fit_pkt = 5'(k);
    if (&pkt_used)
      fit_ok = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_packet_select <= 8'h00;
    else if (mmu_reset)
      tx_packet_select <= 8'h00;
    else if (reg_wr && reg_addr == OFS_PNR)
      tx_packet_select <= reg_wdata[7:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      controller_control <= CTL_RESET;
    else if (tx_done && tx_fatal)
      controller_control[CTL_TRANSMIT_ENABLE_BIT] <= 1'b0;
    else if (reg_wr && reg_addr == OFS_CTL)
      controller_control <= reg_wdata;
  end

  // allocation: result updated on the command, retried each step until met
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      allocation_result <= ARR_RESET;
      alloc_pend        <= 1'b0;
      alloc_cnt         <= 3'h0;
      alloc_timer       <= 16'h0000;
      alloc_done_irq    <= 1'b0;
    end
    else
    begin
      alloc_done_irq <= 1'b0;
      if (mmu_reset)
      begin
        allocation_result <= ARR_RESET;
        alloc_pend        <= 1'b0;
      end
      else if (cmd_wr && cmd == PMM_ALLOC && reg_wdata[3:1] <= PAGE_CNT_MAX)
      begin
        alloc_cnt   <= reg_wdata[3:1];
        alloc_pend  <= 1'b1;
        alloc_timer <= 16'h0000;
        allocation_result[7] <= 1'b1;
      end
      else if (alloc_pend)
      begin
        if (alloc_grant)
        begin
          allocation_result <= {3'b000, fit_pkt};
          alloc_pend        <= 1'b0;
          alloc_done_irq    <= 1'b1;
        end
        else if (alloc_timer == 16'(ALLOC_STEP_CYC - 1))
          alloc_timer <= 16'h0000;
        else
          alloc_timer <= alloc_timer + 16'h0001;
      end
    end
  end

  // release engine shows busy for a few cycles while pages are returned
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rel_state <= PMM_IDLE;
      rel_num   <= 5'h00;
      rel_timer <= 3'h0;
    end
    else if (mmu_reset)
      rel_state <= PMM_IDLE;
    else
      case (rel_state)
        PMM_IDLE:
          if (cmd_wr && cmd == PMM_RX_REL && !rx_queue_empty)
          begin
            rel_state <= PMM_REL;
            rel_num   <= rx_head;
            rel_timer <= 3'(REL_CYC - 1);
          end
          else if (cmd_wr && cmd == PMM_REL_PKT)
          begin
            rel_state <= PMM_REL;
            rel_num   <= tx_packet_select[4:0];
            rel_timer <= 3'(REL_CYC - 1);
          end
        PMM_REL:
          if (rel_timer == 3'h0)
            rel_state <= PMM_IDLE;
          else
            rel_timer <= rel_timer - 3'h1;
        default:
          rel_state <= PMM_IDLE;
      endcase
  end

  assign do_free  = (busy && rel_timer == 3'h0) ||
                    (tx_done && tx_success_flag && !tx_fatal &&
                     controller_control[CTL_AUTO_REL]);
  assign free_num = busy ? rel_num : tx_head;

  // page map: allocation sets, release clears, reset wipes all
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      page_used <= '0;
      pkt_used  <= '0;
    end
    else if (mmu_reset)
    begin
      page_used <= '0;
      pkt_used  <= '0;
    end
    else
    begin
      // a release and a grant may meet in one cycle; both masks must land
      page_used <= (page_used & ~((do_free && pkt_used[free_num]) ?
                                  run_mask(page_base[free_num], page_cnt[free_num]) : '0)) |
                   (alloc_grant ? run_mask(fit_page, alloc_cnt) : '0);
      if (do_free && pkt_used[free_num])
        pkt_used[free_num] <= 1'b0;
      if (alloc_grant)
        pkt_used[fit_pkt] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (alloc_grant)
    begin
      page_base[fit_pkt] <= fit_page;
      page_cnt[fit_pkt]  <= alloc_cnt;
    end
  end

  // chain events: drained when last packet leaves, fault on fatal error
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_queue_drained_irq <= 1'b0;
      tx_fault_irq         <= 1'b0;
      tx_popped            <= 1'b0;
    end
    else
    begin
      tx_fault_irq         <= tx_done && tx_fatal;
      tx_popped            <= tx_pop_done;
      // a send that leaves the queue empty ends the chain
      tx_queue_drained_irq <= tx_popped && tx_queue_empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pmm_fifo u_rx_q
  (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .flush    (mmu_reset),
    .push     (rx_push),
    .push_num (rx_push_num),
    .pop      (rx_pop),
    .head     (rx_head),
    .empty    (rx_queue_empty)
  );

  pmm_fifo u_tx_q
  (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .flush    (tx_flush),
    .push     (cmd_wr && cmd == PMM_ENQ),
    .push_num (tx_packet_select[4:0]),
    .pop      (tx_pop),
    .head     (tx_head),
    .empty    (tx_queue_empty)
  );

  pmm_fifo u_done_q
  (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .flush    (tx_flush),
    .push     (done_push),
    .push_num (tx_head),
    .pop      (1'b0),
    .head     (done_head),
    .empty    (done_queue_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read port; data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (!reg_rd)
      reg_rdata <= 16'h0000;
    else if (reg_addr == OFS_CMD)
      reg_rdata <= {15'h0000, busy};
    else if (reg_addr == OFS_PNR)
      reg_rdata <= {allocation_result, tx_packet_select};
    else if (reg_addr == OFS_FIFO)
      reg_rdata <= {done_queue_empty, 2'b00, done_head,
                    rx_queue_empty, 2'b00, rx_head};
    else if (reg_addr == OFS_CTL)
      reg_rdata <= controller_control;
    else
      reg_rdata <= 16'h0000;
  end

endmodule : pmm_top

/* File: hdl/pmm_pkg.sv */
/*
  Package for the packet memory manager: register offsets, command codes,
  field positions, reset values and timing constants.
  Assumes a 10 MHz system clock.
*/
package pmm_pkg;

  localparam int          CLK_HZ         = 10_000_000;
  localparam logic [3:0]  OFS_CMD        = 4'h0;
  localparam logic [3:0]  OFS_PNR        = 4'h2;
  localparam logic [3:0]  OFS_ARR        = 4'h3;
  localparam logic [3:0]  OFS_FIFO       = 4'h4;
  localparam logic [3:0]  OFS_CTL        = 4'hC;
  localparam int          CTL_AUTO_REL   = 11;
  localparam int          CTL_TRANSMIT_ENABLE_BIT      = 0;
  localparam int          NPKT           = 32;
  localparam int          NPAGE          = 24;
  localparam int          MAX_PAGES      = 6;
  localparam logic [2:0]  PAGE_CNT_MAX   = 3'h5;
  localparam int          ALLOC_STEP_US  = 200;
  localparam int          ALLOC_STEP_CYC = (ALLOC_STEP_US * (CLK_HZ / 1_000_000));
  localparam int          REL_CYC        = 4;
  localparam logic [7:0]  ARR_RESET      = 8'h80;
  localparam logic [15:0] CTL_RESET      = 16'h0000;

  typedef enum logic [3:0] {
    PMM_NOOP     = 4'h0,
    PMM_ALLOC    = 4'h2,
    PMM_RESET    = 4'h4,
    PMM_RX_POP   = 4'h6,
    PMM_TX_POP   = 4'h7,
    PMM_RX_REL   = 4'h8,
    PMM_REL_PKT  = 4'hA,
    PMM_ENQ      = 4'hC,
    PMM_TX_RESET = 4'hE
  } pmm_cmd_t;

  typedef enum logic [1:0] {
    PMM_IDLE = 2'b00,
    PMM_REL  = 2'b01
  } pmm_rel_state_t;

endpackage : pmm_pkg

/* File: hdl/pmm_fifo.sv */
/*
  Packet-number queue with pop, push and flush.
  Assumes one clock and a synchronous flush; push when full is dropped.
*/
`timescale 1ns/1ps
module pmm_fifo
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       flush,
  input  wire logic       push,
  input  wire logic [4:0] push_num,
  input  wire logic       pop,
  output logic      [4:0] head,
  output logic            empty
);
  import pmm_pkg::*;

  logic [4:0] mem [NPKT];
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic       full;

  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[4:0] == rd_ptr[4:0]) && (wr_ptr[5] != rd_ptr[5]);
  assign head  = mem[rd_ptr[4:0]];

  always_ff @(posedge sys_clk)
  begin
    if (push && !full)
      mem[wr_ptr[4:0]] <= push_num;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
    end
    else if (flush)
    begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
    end
    else
    begin
      if (push && !full)
        wr_ptr <= wr_ptr + 6'h01;
      if (pop && !empty)
        rd_ptr <= rd_ptr + 6'h01;
    end
  end

endmodule : pmm_fifo

/* File: testbench/pmm_assertions.sv */
/*
  Port checker for the packet memory manager.
  Assumes one clock and a bind onto pmm_top.
*/
`timescale 1ns/1ps
module pmm_checker
(
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        reg_wr,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        rx_push,
  input wire logic        tx_done,
  input wire logic        tx_fatal,
  input wire logic        tx_queue_empty,
  input wire logic        tx_pop_done,
  input wire logic [4:0]  tx_area_packet,
  input wire logic        transmit_enable_bit,
  input wire logic        tx_fault_irq,
  input wire logic        tx_queue_drained_irq,
  input wire logic        rx_queue_empty,
  input wire logic        done_queue_empty
);
  import pmm_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic       cmd_wr;
  logic       fatal_ev;
  logic [3:0] code;
  logic [4:0] wsel;
  // concurrent queue traffic would mask a command's own effect
  assign cmd_wr   = reg_wr && reg_addr == OFS_CMD && !rx_push && !tx_done;
  assign fatal_ev = tx_done && tx_fatal;
  assign code     = reg_wdata[7:4];
  assign wsel     = reg_wdata[4:0];
  ////////////////////////////////////////////////////////////////////////////
  pop_strobe_a: assert property (tx_pop_done == (tx_done && !tx_fatal))
    else $error("pop strobe wrong");
  fatal_stop_a: assert property (fatal_ev |=> !transmit_enable_bit)
    else $error("enable kept after fatal");
  fatal_keep_a: assert property (fatal_ev && !tx_queue_empty |-> ##[1:2] !done_queue_empty)
    else $error("failed packet not shown");
  fatal_hold_a: assert property (fatal_ev && !tx_queue_empty |=> !tx_queue_empty)
    else $error("failed packet left the queue");
  fault_cause_a: assert property (tx_fault_irq |-> $past(fatal_ev))
    else $error("fault event without cause");
  drain_cause_a: assert property (tx_queue_drained_irq |->
    $past(tx_queue_empty) && $past(tx_pop_done, 2))
    else $error("drained event without a final send");
  noop_hold_a: assert property (cmd_wr && code == 4'h0 |=>
    $stable(tx_queue_empty) && $stable(rx_queue_empty) && $stable(tx_area_packet))
    else $error("noop changed state");
  enq_fill_a: assert property (cmd_wr && code == 4'hC |=> !tx_queue_empty)
    else $error("enqueue lost");
  tx_flush_a: assert property (cmd_wr && code == 4'hE |=>
    tx_queue_empty && done_queue_empty)
    else $error("transmit queues not flushed");
  mmu_reset_a: assert property (cmd_wr && code == 4'h4 |=> tx_queue_empty &&
    rx_queue_empty && done_queue_empty && tx_area_packet == 5'h00)
    else $error("manager reset incomplete");
  select_wr_a: assert property (reg_wr && reg_addr == OFS_PNR |=>
    tx_area_packet == $past(wsel))
    else $error("packet select not loaded");
  cover property (fatal_ev);
  cover property (tx_queue_drained_irq);
  cover property (cmd_wr && code == 4'hE);
  cover property (cmd_wr && code == 4'h4);
endmodule : pmm_checker

bind pmm_top pmm_checker chk_i (.*);

/* File: testbench/pmm_tx_engine.sv */
/*
  Transmit engine model: sends the queue head while transmit is enabled.
  Assumes the bench sets fail_req to command a fatal end.
*/
`timescale 1ns/1ps
module pmm_tx_engine
#(
  parameter int DLY = 6
)
(
  input  wire logic sys_clk,
  input  wire logic transmit_enable_bit,
  input  wire logic tx_queue_empty,
  input  wire logic fail_req,
  output logic      tx_done,
  output logic      tx_success_flag,
  output logic      tx_fatal
);
  int cnt = 0;
  initial
  begin
    tx_done = 1'b0;
    tx_success_flag = 1'b0;
    tx_fatal = 1'b1;
  end
  // status levels churn outside the strobe, so only tx_done qualifies them
  always @(posedge sys_clk)
  begin
    tx_done <= 1'b0;
    tx_success_flag <= ~tx_success_flag;
    tx_fatal <= ~tx_fatal;
    if (!transmit_enable_bit || tx_queue_empty || tx_done)
      cnt <= 0;
    else if (cnt == DLY)
    begin
      cnt <= 0;
      tx_done <= 1'b1;
      tx_success_flag <= !fail_req;
      tx_fatal <= fail_req;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : pmm_tx_engine

/* File: testbench/packet_memory_manager_test.sv */
/*
  Self-checking bench for the packet memory manager.
  Assumes the transmit engine model on the far side of the queue ports.
*/
`timescale 1ns/1ps
module packet_memory_manager_test;
  import pmm_pkg::*;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, rx_push = 1'b0, fail_req = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic [4:0]  rx_push_num = 5'h00, tx_head, tx_area_packet, rx_head, pn;
  logic [4:0]  pk [6];
  logic        tx_done, tx_success_flag, tx_fatal, tx_queue_empty, tx_pop_done;
  logic        transmit_enable_bit, alloc_done_irq, tx_queue_drained_irq;
  logic        tx_fault_irq, rx_queue_empty, done_queue_empty;
  int          error_cnt = 0, checks_done = 0;
  logic [3:0]  odd [8] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h9, 4'hB, 4'hD, 4'hF};
  always #50 sys_clk = ~sys_clk;
  pmm_top dut (.*);
  pmm_tx_engine eng (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wait_bit(ref logic b, input logic v, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (b === v)
        break;
    end
    chk({15'h0, b}, {15'h0, v});
  endtask : wait_bit
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #5_000_000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(OFS_PNR, d);
    chk(d, {ARR_RESET, 8'h00});
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_CMD, {8'h00, odd[i], 4'h0});
      rd(OFS_PNR, d);
      chk(d, 16'h8000);
      chk({13'h0, tx_queue_empty, rx_queue_empty, done_queue_empty}, 16'h0007);
    end
    for (int n = 0; n < MAX_PAGES; n++)
    begin
      wr(OFS_CMD, {8'h00, 4'h2, 3'(n), 1'b0});
      wait_bit(alloc_done_irq, 1'b1, (n + 2) * ALLOC_STEP_CYC);
      rd(OFS_PNR, d);
      chk({15'h0, d[15]}, 16'h0000);
      pk[n] = d[12:8];
    end
    // only three pages remain, so six pages must fail and stay pending
    wr(OFS_CMD, 16'h002A);
    rd(OFS_PNR, d);
    chk({15'h0, d[15]}, 16'h0001);
    wr(OFS_PNR, {11'h0, pk[5]});
    chk({11'h0, tx_area_packet}, {11'h0, pk[5]});
    wr(OFS_CMD, 16'h00A0);
    rd(OFS_CMD, d);
    chk({15'h0, d[0]}, 16'h0001);
    wait_bit(alloc_done_irq, 1'b1, 7 * ALLOC_STEP_CYC);
    rd(OFS_PNR, d);
    chk({15'h0, d[15]}, 16'h0000);
    pn = d[12:8];
    rd(OFS_CMD, d);
    chk({15'h0, d[0]}, 16'h0000);
    wr(OFS_CTL, 16'h0801);
    wr(OFS_PNR, {11'h0, pn});
    wr(OFS_CMD, 16'h00C0);
    wait_bit(tx_queue_empty, 1'b1, 40);
    wait_bit(tx_queue_drained_irq, 1'b1, 4);
    chk({15'h0, done_queue_empty}, 16'h0001);
    wr(OFS_CTL, 16'h0800);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_PNR, {11'h0, pk[i]});
      wr(OFS_CMD, 16'h00C0);
    end
    chk({11'h0, tx_head}, {11'h0, pk[0]});
    fail_req = 1'b1;
    wr(OFS_CTL, 16'h0801);
    wait_bit(done_queue_empty, 1'b0, 40);
    chk({15'h0, tx_fault_irq}, 16'h0001);
    chk({14'h0, transmit_enable_bit, tx_queue_empty}, 16'h0000);
    chk({11'h0, tx_head}, {11'h0, pk[0]});
    fail_req = 1'b0;
    wr(OFS_CMD, 16'h0070);
    chk({11'h0, tx_head}, {11'h0, pk[1]});
    wr(OFS_CMD, 16'h00E0);
    chk({14'h0, tx_queue_empty, done_queue_empty}, 16'h0003);
    for (int i = 2; i < 4; i++)
    begin
      @(posedge sys_clk);
      rx_push <= 1'b1;
      rx_push_num <= pk[i];
      @(posedge sys_clk);
      rx_push <= 1'b0;
      rx_push_num <= ~pk[i];
    end
    #1;
    chk({10'h0, rx_queue_empty, rx_head}, {11'h0, pk[2]});
    wr(OFS_CMD, 16'h0060);
    chk({10'h0, rx_queue_empty, rx_head}, {11'h0, pk[3]});
    wr(OFS_CMD, 16'h0080);
    chk({15'h0, rx_queue_empty}, 16'h0001);
    repeat (6) @(posedge sys_clk);
    wr(OFS_PNR, {11'h0, pk[4]});
    wr(OFS_CMD, 16'h0040);
    rd(OFS_PNR, d);
    chk(d, 16'h8000);
    give_verdict();
  end
endmodule : packet_memory_manager_test
